// [core/sfp_pkg.sv]
package sfp_pkg;
   // Register byte addresses on the APB bus
   localparam logic [11:0] SFP_DATA_OFS = 12'h000;
   localparam logic [11:0] SFP_CTRL_OFS = 12'h004;
   localparam logic [11:0] SFP_CSR_OFS  = 12'h008;
   localparam logic [11:0] SFP_ST_OFS   = 12'h00C;
   // Control register fields
   localparam int CR_IRQEN  = 7;
   localparam int CR_PEN    = 6;
   localparam int CR_HALVER = 5;
   localparam int CR_MASTER_SELECT   = 4;
   localparam int CR_CLOCK_IDLE_LEVEL   = 3;
   localparam int CR_CAPTURE_EDGE_SELECT   = 2;
   localparam logic [7:0] CR_RESET = 8'h00;
   // Control/status register fields
   localparam int CS_DONE = 7;
   localparam int CS_WRITE_COLLISION_FLAG = 6;
   localparam int CS_OVR  = 5;
   localparam int CS_MASTER_FAULT_FLAG = 4;
   localparam int CS_SOD  = 2;
   localparam int CS_SSM  = 1;
   localparam int CS_SSI  = 0;
   localparam logic [2:0] CS_SW_MASK = 3'h7;
   localparam logic [7:0] CS_RESET  = 8'h00;
   localparam int BITS_PER_BYTE = 8;
   typedef enum logic [1:0] {
      SFP_IDLE  = 2'b00,
      SFP_SHIFT = 2'b01,
      SFP_DONE  = 2'b10
   } sfp_state_t;
endpackage

// [core/sfp_port.sv]
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// RULE_01 - As master, a low slave select sets the master fault flag.
// RULE_02 - Master fault clears port enable and master select, forcing slave operation.
// RULE_03 - Master fault clears after status read while set, then control write.
// RULE_04 - During master fault, writes setting enable or master are refused, except clearing write.
// RULE_05 - Other party holds slave select high during the fault clearing sequence.
// RULE_06 - Byte completing while done flag set sets overrun and requests interrupt.
// RULE_07 - On overrun the buffer keeps the first byte; later bytes are dropped.
// RULE_08 - Overrun flag clears when software reads the status register.
// RULE_09 - Data write during a transfer is ignored and sets write collision.
// RULE_10 - Write collision never raises an interrupt.
// RULE_11 - Write collision clears by status read then data read after a byte.
// RULE_12 - Received bytes go to a buffer separate from the shift register.
// RULE_13 - In wait state the port runs and its interrupts wake the processor.
// RULE_14 - In halt state registers hold and the port is inactive; the code freezes only a master, a slave keeps shifting.
// RULE_15 - Slave completion wakes from halt; fault and overrun do not.
// RULE_16 - Slave select must be low when halt is entered for wake.
// RULE_17 - After halt wake as slave, software runs one extra transfer.
// RULE_18 - One interrupt request for done, fault and overrun when enabled.
// RULE_19 - Port enable in bit 6 resets to zero; pins are general I/O.
// RULE_20 - Master select in bit 4 drives clock out and swaps data pins.
// RULE_21 - Bit 3 sets the serial clock idle level in both modes.
// RULE_22 - Bit 2 selects first or second clock transition as capture edge.
// RULE_23 - Master clock is CPU clock divided by rate bits, /4 to /128.
// RULE_24 - All logic runs on the CPU clock; reset restores controls and flags.
module sfp_port
   import sfp_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        halt_mode,
   output logic             irq,
   output logic             halt_wake,
   input  wire logic        sel_n_in,
   input  wire logic        sck_in,
   output logic             sck_out,
   output logic             sck_oe_n,
   input  wire logic        mosi_in,
   output logic             mosi_out,
   output logic             mosi_oe_n,
   input  wire logic        miso_in,
   output logic             miso_out,
   output logic             miso_oe_n,
   output logic             port_active
);
   import sfp_pkg::*;

   logic [7:0]  ctrl_r, ctrl_nxt;
   logic [7:0]  csr_r, csr_nxt;
   logic [7:0]  shift_r, shift_nxt;
   logic [7:0]  rxbuf_r, rxbuf_nxt;
   logic [3:0]  bitcnt_r, bitcnt_nxt;
   logic [6:0]  div_r, div_nxt;
   logic        sck_r, sck_nxt;
   logic        sck_in_q_r;
   logic        master_fault_flag_armed_r, master_fault_flag_armed_nxt;
   logic        done_armed_r, done_armed_nxt;
   logic        write_collision_flag_armed_r, write_collision_flag_armed_nxt;
   logic        busy_r, busy_nxt;
   sfp_state_t  st_r, st_nxt;

   logic wr, rd, sel_int, master, enabled, sck_edge_int, lead, byte_done;
   logic [6:0] div_lim;

   function automatic logic [6:0] rate_limit(input logic halver_off, input logic [1:0] rs);
      logic [2:0] code;
      code = {halver_off, rs};
      case (code)
         3'b100:  rate_limit = 7'h01;
         3'b000:  rate_limit = 7'h03;
         3'b001:  rate_limit = 7'h07;
         3'b110:  rate_limit = 7'h0F;
         3'b010:  rate_limit = 7'h1F;
         3'b011:  rate_limit = 7'h3F;
         default: rate_limit = 7'h03;
      endcase
   endfunction

   assign wr      = psel && penable && pwrite;
   assign rd      = psel && penable && !pwrite;
   assign pready  = 1'b1;
   assign sel_int = csr_r[CS_SSM] ? csr_r[CS_SSI] : sel_n_in;
   assign master  = ctrl_r[CR_MASTER_SELECT];
   // Halt stops the master's own clock and freezes its shift register and bit count
   // A slave keeps following the far clock so a finished byte can end halt
   // Trade-off: slave state may move in halt, which is what makes wake possible
   assign enabled = ctrl_r[CR_PEN] && !(halt_mode && master); // [RULE_14] [RULE_15]
   assign port_active = ctrl_r[CR_PEN]; // [RULE_19]
   assign div_lim = rate_limit(ctrl_r[CR_HALVER], ctrl_r[1:0]); // [RULE_23]

   always_comb begin
      pslverr = 1'b0;
      if (psel && !(paddr == SFP_DATA_OFS || paddr == SFP_CTRL_OFS ||
                    paddr == SFP_CSR_OFS || paddr == SFP_ST_OFS)) begin
         pslverr = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_in_q_r <= 1'b0;
      end else begin
         sck_in_q_r <= sck_in;
      end
   end

   // Edge from own divider in master mode, from the pin in slave mode
   always_comb begin
      div_nxt      = div_r;
      sck_nxt      = sck_r;
      sck_edge_int = 1'b0;
      if (!enabled || !busy_r) begin
         div_nxt = 7'h00;
         sck_nxt = ctrl_r[CR_CLOCK_IDLE_LEVEL]; // [RULE_21]
      end else if (master) begin
         if (div_r == div_lim) begin
            div_nxt      = 7'h00;
            sck_nxt      = !sck_r;
            sck_edge_int = 1'b1;
         end else begin
            div_nxt = div_r + 7'h01;
         end
      end else begin
         sck_edge_int = (sck_in != sck_in_q_r) && !sel_int;
      end
   end

   // Capture on the leading transition when phase is 0, on the trailing one when 1
   always_comb begin
      logic cur;
      cur  = master ? sck_r : sck_in_q_r;
      lead = (cur == ctrl_r[CR_CLOCK_IDLE_LEVEL]);
      lead = ctrl_r[CR_CAPTURE_EDGE_SELECT] ? !lead : lead; // [RULE_22]
   end

   always_comb begin
      st_nxt     = st_r;
      shift_nxt  = shift_r;
      bitcnt_nxt = bitcnt_r;
      busy_nxt   = busy_r;
      byte_done  = 1'b0;
      case (st_r)
         SFP_IDLE: begin
            bitcnt_nxt = 4'h0;
            if (busy_r && enabled) begin
               st_nxt = SFP_SHIFT;
            end else if (enabled && !master && !sel_int) begin
               busy_nxt = 1'b1;
               st_nxt   = SFP_SHIFT;
            end
         end
         SFP_SHIFT: begin
            // Disable or slave deselect ends a cut frame, so a stale busy never blocks writes
            if (!ctrl_r[CR_PEN] || (!master && sel_int)) begin
               st_nxt     = SFP_IDLE;
               busy_nxt   = 1'b0;
               bitcnt_nxt = 4'h0;
            end else if (!enabled) begin
               st_nxt = SFP_SHIFT;
            end else if (sck_edge_int && lead) begin
               shift_nxt  = {shift_r[6:0], master ? miso_in : mosi_in};
               bitcnt_nxt = bitcnt_r + 4'h1;
               if (bitcnt_r == 4'(BITS_PER_BYTE - 1)) begin
                  st_nxt = SFP_DONE;
               end
            end
         end
         SFP_DONE: begin
            byte_done = 1'b1;
            busy_nxt  = 1'b0;
            st_nxt    = SFP_IDLE;
         end
         default: st_nxt = SFP_IDLE;
      endcase
      if (wr && paddr == SFP_DATA_OFS && !busy_r && enabled && !csr_r[CS_DONE]) begin
         shift_nxt = pwdata[7:0];
         busy_nxt  = master;
         st_nxt    = master ? SFP_SHIFT : st_r;
      end
   end

   always_comb begin
      logic fault;
      logic cs_rd, cr_wr, dr_rd, dr_wr;
      ctrl_nxt       = ctrl_r;
      csr_nxt        = csr_r;
      rxbuf_nxt      = rxbuf_r;
      master_fault_flag_armed_nxt = master_fault_flag_armed_r;
      done_armed_nxt = done_armed_r;
      write_collision_flag_armed_nxt = write_collision_flag_armed_r;
      cs_rd = rd && paddr == SFP_CSR_OFS;
      cr_wr = wr && paddr == SFP_CTRL_OFS;
      dr_rd = rd && paddr == SFP_DATA_OFS;
      dr_wr = wr && paddr == SFP_DATA_OFS;
      fault = master && ctrl_r[CR_PEN] && !sel_int; // [RULE_01]
      if (cs_rd && csr_r[CS_MASTER_FAULT_FLAG]) master_fault_flag_armed_nxt = 1'b1;
      if (cs_rd && csr_r[CS_DONE]) done_armed_nxt = 1'b1;
      if (cs_rd && csr_r[CS_WRITE_COLLISION_FLAG]) write_collision_flag_armed_nxt = 1'b1;
      if (cs_rd) csr_nxt[CS_OVR] = 1'b0; // [RULE_08]
      if (cr_wr) begin
         ctrl_nxt = pwdata[7:0];
         if (csr_r[CS_MASTER_FAULT_FLAG] && !master_fault_flag_armed_r) begin
            ctrl_nxt[CR_PEN]  = 1'b0; // [RULE_04]
            ctrl_nxt[CR_MASTER_SELECT] = 1'b0; // [RULE_04]
         end
         if (master_fault_flag_armed_r) begin
            csr_nxt[CS_MASTER_FAULT_FLAG] = 1'b0; // [RULE_03]
            master_fault_flag_armed_nxt   = 1'b0;
         end
      end
      if (wr && paddr == SFP_CSR_OFS) csr_nxt[2:0] = pwdata[2:0] & CS_SW_MASK;
      if ((dr_rd || dr_wr) && done_armed_r) begin
         csr_nxt[CS_DONE] = 1'b0;
         done_armed_nxt   = 1'b0;
      end
      if (dr_rd && write_collision_flag_armed_r) begin
         csr_nxt[CS_WRITE_COLLISION_FLAG] = 1'b0; // [RULE_11]
         write_collision_flag_armed_nxt   = 1'b0;
      end
      // Collision set after the clear so a new collision wins
      if (dr_wr && (busy_r || csr_r[CS_DONE])) csr_nxt[CS_WRITE_COLLISION_FLAG] = 1'b1; // [RULE_09]
      if (byte_done) begin
         if (csr_r[CS_DONE] && !(done_armed_r && (dr_rd || dr_wr))) begin
            csr_nxt[CS_OVR] = 1'b1; // [RULE_06] [RULE_07]
         end else begin
            rxbuf_nxt        = shift_r; // [RULE_12]
            csr_nxt[CS_DONE] = 1'b1;
         end
      end
      if (fault) begin
         csr_nxt[CS_MASTER_FAULT_FLAG]  = 1'b1;
         ctrl_nxt[CR_PEN]  = 1'b0; // [RULE_02]
         ctrl_nxt[CR_MASTER_SELECT] = 1'b0; // [RULE_02]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r       <= CR_RESET; // [RULE_24]
         csr_r        <= CS_RESET;
         shift_r      <= 8'h00;
         rxbuf_r      <= 8'h00;
         bitcnt_r     <= 4'h0;
         div_r        <= 7'h00;
         sck_r        <= 1'b0;
         master_fault_flag_armed_r <= 1'b0;
         done_armed_r <= 1'b0;
         write_collision_flag_armed_r <= 1'b0;
         busy_r       <= 1'b0;
         st_r         <= SFP_IDLE;
      end else begin
         ctrl_r       <= ctrl_nxt;
         csr_r        <= csr_nxt;
         shift_r      <= shift_nxt;
         rxbuf_r      <= rxbuf_nxt;
         bitcnt_r     <= bitcnt_nxt;
         div_r        <= div_nxt;
         sck_r        <= sck_nxt;
         master_fault_flag_armed_r <= master_fault_flag_armed_nxt;
         done_armed_r <= done_armed_nxt;
         write_collision_flag_armed_r <= write_collision_flag_armed_nxt;
         busy_r       <= busy_nxt;
         st_r         <= st_nxt;
      end
   end

   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         SFP_DATA_OFS: prdata[7:0] = rxbuf_r;
         SFP_CTRL_OFS: prdata[7:0] = ctrl_r;
         SFP_CSR_OFS:  prdata[7:0] = {csr_r[7:4], 1'b0, csr_r[2:0]};
         SFP_ST_OFS:   prdata[1:0] = {halt_wake, busy_r};
         default:      prdata = 32'h0000_0000;
      endcase
   end

   // Write collision is deliberately left out of the request
   assign irq = ctrl_r[CR_IRQEN] &&
                (csr_r[CS_DONE] || csr_r[CS_MASTER_FAULT_FLAG] || csr_r[CS_OVR]); // [RULE_18] [RULE_10] [RULE_13]
   // Only transfer completion may leave halt
   assign halt_wake = ctrl_r[CR_IRQEN] && csr_r[CS_DONE] && !master; // [RULE_15]

   // Master drives clock and data out; slave drives the return line
   assign sck_out   = sck_r;
   assign sck_oe_n  = !(ctrl_r[CR_PEN] && master); // [RULE_20]
   assign mosi_out  = shift_r[7];
   assign mosi_oe_n = !(ctrl_r[CR_PEN] && master && !csr_r[CS_SOD]);
   assign miso_out  = shift_r[7];
   assign miso_oe_n = !(ctrl_r[CR_PEN] && !master && !sel_int && !csr_r[CS_SOD]);

   a_fault_drops_mode: assert property (@(posedge pclk) disable iff (!presetn)
      (master && ctrl_r[CR_PEN] && !sel_int) |=> (csr_r[CS_MASTER_FAULT_FLAG] && !ctrl_r[CR_PEN] && !ctrl_r[CR_MASTER_SELECT]))
      else $error("fault did not disable port"); // [RULE_02]
   a_fault_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(csr_r[CS_MASTER_FAULT_FLAG]) |-> $past(master && !sel_int))
      else $error("fault flag without cause"); // [RULE_01]
   a_fault_refuse: assert property (@(posedge pclk) disable iff (!presetn)
      (csr_r[CS_MASTER_FAULT_FLAG] && !master_fault_flag_armed_r && wr && paddr == SFP_CTRL_OFS) |=> !ctrl_r[CR_PEN] && !ctrl_r[CR_MASTER_SELECT])
      else $error("enable accepted during fault"); // [RULE_04]
   a_fault_clear: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(csr_r[CS_MASTER_FAULT_FLAG]) |-> $past(master_fault_flag_armed_r && wr && paddr == SFP_CTRL_OFS))
      else $error("fault flag cleared wrongly"); // [RULE_03]
   a_ovr_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (rd && paddr == SFP_CSR_OFS && !byte_done) |=> !csr_r[CS_OVR])
      else $error("overrun not cleared by read"); // [RULE_08]
   a_ovr_keeps_buf: assert property (@(posedge pclk) disable iff (!presetn)
      (byte_done && csr_r[CS_DONE] && !done_armed_r) |=> (csr_r[CS_OVR] && $stable(rxbuf_r)))
      else $error("overrun lost first byte"); // [RULE_07]
   a_write_collision_flag_no_irq: assert property (@(posedge pclk) disable iff (!presetn)
      (!ctrl_r[CR_IRQEN] || !(csr_r[CS_DONE] || csr_r[CS_MASTER_FAULT_FLAG] || csr_r[CS_OVR])) |-> !irq)
      else $error("irq without event"); // [RULE_10]
   a_write_collision_flag_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == SFP_DATA_OFS && busy_r && st_r == SFP_SHIFT && !sck_edge_int) |=> $stable(shift_r))
      else $error("colliding write changed shift"); // [RULE_09]
   a_halt_frozen: assert property (@(posedge pclk) disable iff (!presetn)
      (halt_mode && $past(halt_mode) && master && !psel) |=> $stable(shift_r) && $stable(bitcnt_r))
      else $error("port active in halt"); // [RULE_14]
   // Flag, interrupt, pin-enable and clock relations checked every cycle, independent of the bench
   a_done_copies_buf: assert property (@(posedge pclk) disable iff (!presetn)
      (byte_done && !csr_r[CS_DONE]) |=> (csr_r[CS_DONE] && rxbuf_r == $past(shift_r)))
      else $error("received byte not buffered"); // [RULE_12]
   a_ovr_irq: assert property (@(posedge pclk) disable iff (!presetn)
      (csr_r[CS_OVR] && ctrl_r[CR_IRQEN]) |-> irq)
      else $error("overrun without irq"); // [RULE_06]
   a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_r[CR_IRQEN] |-> !irq)
      else $error("irq while disabled"); // [RULE_18]
   a_fault_irq: assert property (@(posedge pclk) disable iff (!presetn)
      (csr_r[CS_MASTER_FAULT_FLAG] && ctrl_r[CR_IRQEN]) |-> irq)
      else $error("fault without irq"); // [RULE_18]
   a_wait_irq: assert property (@(posedge pclk) disable iff (!presetn)
      (!halt_mode && ctrl_r[CR_IRQEN] && csr_r[CS_DONE]) |-> irq)
      else $error("done without irq in run"); // [RULE_13]
   a_wake_only_done: assert property (@(posedge pclk) disable iff (!presetn)
      halt_wake |-> (csr_r[CS_DONE] && !master))
      else $error("wake without slave done"); // [RULE_15]
   a_fault_no_wake: assert property (@(posedge pclk) disable iff (!presetn)
      (csr_r[CS_MASTER_FAULT_FLAG] && !csr_r[CS_DONE]) |-> !halt_wake)
      else $error("fault woke from halt"); // [RULE_15]
   a_master_oe: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_r[CR_PEN] && master) |-> !sck_oe_n)
      else $error("master clock not driven"); // [RULE_20]
   a_off_no_oe: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_r[CR_PEN] |-> (sck_oe_n && mosi_oe_n && miso_oe_n))
      else $error("pins driven while disabled"); // [RULE_19]
   a_idle_level: assert property (@(posedge pclk) disable iff (!presetn)
      (!busy_r || !enabled) |=> sck_r == $past(ctrl_r[CR_CLOCK_IDLE_LEVEL]))
      else $error("clock not at idle level"); // [RULE_21]
   a_write_collision_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == SFP_DATA_OFS && busy_r) |=> csr_r[CS_WRITE_COLLISION_FLAG])
      else $error("collision not flagged"); // [RULE_09]
   a_div_bound: assert property (@(posedge pclk) disable iff (!presetn)
      (master && busy_r) |-> div_r <= div_lim)
      else $error("divider out of range"); // [RULE_23]
   // Covers for the main traffic shapes
   c_slave_byte: cover property (@(posedge pclk) disable iff (!presetn) byte_done && !master);
   c_master_byte: cover property (@(posedge pclk) disable iff (!presetn) byte_done && master);
   c_fault: cover property (@(posedge pclk) disable iff (!presetn) $rose(csr_r[CS_MASTER_FAULT_FLAG]));
   c_overrun: cover property (@(posedge pclk) disable iff (!presetn) $rose(csr_r[CS_OVR]));
   c_wake: cover property (@(posedge pclk) disable iff (!presetn) halt_mode && halt_wake);
endmodule // sfp_port

// [sim/sfp_far_end.sv]
`timescale 1ns/1ns
module sfp_far_end #(
   parameter int HALF = 6
) (
   input  wire logic pclk,
   input  wire logic miso_out,
   output logic      sel_n,
   output logic      sck,
   output logic      mosi,
   output logic      miso
);
   bit busy = 1'b0;
   initial begin
      sel_n = 1'b1;
      sck = 1'b0;
      mosi = 1'b0;
      miso = 1'b0;
   end
   // Released data lines carry a changing pattern, so a stale bit is never mistaken for data
   always @(posedge pclk) begin
      miso <= ~miso;
      if (!busy) mosi <= ~mosi;
   end
   task automatic set_sel(input logic v);
      @(posedge pclk);
      sel_n <= v;
   endtask
   // Acts as master on the link; clock settles at its idle level before select falls
   task automatic xfer(input logic [7:0] tx, input logic clock_idle_level, input logic capture_edge_select, output logic [7:0] rx);
      busy = 1'b1;
      @(posedge pclk);
      sck <= clock_idle_level;
      repeat (HALF) @(posedge pclk);
      sel_n <= 1'b0;
      repeat (HALF) @(posedge pclk);
      for (int i = 7; i >= 0; i--) begin
         if (capture_edge_select) sck <= ~clock_idle_level;
         mosi <= tx[i];
         repeat (HALF - 1) @(posedge pclk);
         @(negedge pclk);
         rx[i] = miso_out;
         @(posedge pclk);
         sck <= capture_edge_select ? clock_idle_level : ~clock_idle_level;
         repeat (HALF) @(posedge pclk);
         if (!capture_edge_select) sck <= clock_idle_level;
      end
      repeat (HALF) @(posedge pclk);
      sel_n <= 1'b1;
      mosi <= ~mosi;
      @(posedge pclk);
      busy = 1'b0;
   endtask
endmodule // sfp_far_end

// [sim/spi_fault_power_and_control_bench.sv]
`timescale 1ns/1ns
module spi_fault_power_and_control_bench;
   import sfp_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        halt_mode = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, halt_wake, sel_n, sck, mosi, miso;
   logic        sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, port_active;
   logic [31:0] seed = 32'd98761;
   logic [7:0]  r, tx, rx, b;
   logic        err, clock_idle_level, prev;
   logic [7:0]  rxq[$];
   int          mismatches = 0;
   int          checks_done = 0;
   int          n, edges, per;
   int          div_tab[6] = '{4, 8, 16, 32, 64, 128};
   logic [2:0]  code_tab[6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};

   always #2 pclk = ~pclk;

   sfp_port i_sfp_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_mode(halt_mode),
      .irq(irq), .halt_wake(halt_wake), .sel_n_in(sel_n), .sck_in(sck), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
      .mosi_in(mosi), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso), .miso_out(miso_out),
      .miso_oe_n(miso_oe_n), .port_active(port_active));
   sfp_far_end far (.pclk(pclk), .miso_out(miso_out), .sel_n(sel_n), .sck(sck), .mosi(mosi), .miso(miso));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Zero-wait slave, but the master still waits on pready with a bound
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] rd);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         mismatches++;
         summarize();
      end
      @(negedge pclk);
   endtask

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      bus(0, SFP_CTRL_OFS, 8'h00, r);
      check("ctrl reset", r, CR_RESET);
      bus(0, SFP_CSR_OFS, 8'h00, r);
      check("csr reset", r, CS_RESET);
      check("active reset", port_active, 1'b0);
      bus(0, 12'h010, 8'h00, r);
      check("unmapped", err, 1'b1);
      bus(1, SFP_CTRL_OFS, 8'hD0, r);
      check("master clock oe", sck_oe_n, 1'b0);
      far.set_sel(1'b0);
      repeat (3) @(posedge pclk);
      bus(0, SFP_CTRL_OFS, 8'h00, r);
      check("ctrl after fault", r, 8'h80);
      check("fault irq", irq, 1'b1);
      check("fault no wake", halt_wake, 1'b0);
      bus(1, SFP_CTRL_OFS, 8'hD0, r);
      bus(0, SFP_CTRL_OFS, 8'h00, r);
      check("refused ctrl", r, 8'h80);
      far.set_sel(1'b1);
      bus(0, SFP_CSR_OFS, 8'h00, r);
      check("fault flag", r[CS_MASTER_FAULT_FLAG], 1'b1);
      bus(1, SFP_CTRL_OFS, 8'h40, r);
      bus(0, SFP_CSR_OFS, 8'h00, r);
      check("fault cleared", r[CS_MASTER_FAULT_FLAG], 1'b0);
      for (int m = 0; m < 4; m++) begin
         bus(1, SFP_CTRL_OFS, 8'h00, r);
         bus(1, SFP_CTRL_OFS, 8'h40 | 8'(m << 2), r);
         seed = lfsr(seed);
         tx = seed[7:0];
         seed = lfsr(seed);
         b = seed[7:0];
         bus(1, SFP_DATA_OFS, tx, r);
         far.xfer(b, m[1], m[0], rx);
         rxq.push_back(b);
         check("slave out", rx, tx);
         if (m == 3) begin
            bus(1, SFP_DATA_OFS, 8'h55, r);
            check("write_collision_flag no irq", irq, 1'b0);
         end
         bus(0, SFP_CSR_OFS, 8'h00, r);
         check("flags set", r & 8'hF0, (m == 3) ? 8'hC0 : 8'h80);
         bus(0, SFP_DATA_OFS, 8'h00, r);
         check("rx buffer", r, rxq.pop_front());
         bus(0, SFP_CSR_OFS, 8'h00, r);
         check("flags clear", r & 8'hF0, 8'h00);
      end
      bus(1, SFP_CTRL_OFS, 8'hC0, r);
      far.set_sel(1'b0);
      halt_mode <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         seed = lfsr(seed);
         b = seed[7:0];
         far.xfer(b, 1'b0, 1'b0, rx);
         rxq.push_back(b);
      end
      check("done irq", irq, 1'b1);
      check("done wake", halt_wake, 1'b1);
      halt_mode <= 1'b0;
      bus(0, SFP_CSR_OFS, 8'h00, r);
      check("overrun set", r & 8'hF0, (rxq.size() > 1) ? 8'hA0 : 8'h80);
      bus(0, SFP_CSR_OFS, 8'h00, r);
      check("overrun cleared", r & 8'hF0, 8'h80);
      bus(0, SFP_DATA_OFS, 8'h00, r);
      check("first byte kept", r, rxq[0]);
      rxq.delete();
      check("irq released", irq, 1'b0);
      for (int i = 0; i < 6; i++) begin
         clock_idle_level = i[0];
         bus(1, SFP_CTRL_OFS, 8'h00, r);
         bus(1, SFP_CTRL_OFS, {2'b01, code_tab[i][2], 1'b1, clock_idle_level, 1'b0, code_tab[i][1:0]}, r);
         @(negedge pclk);
         check("idle level", sck_out, clock_idle_level);
         check("master data oe", mosi_oe_n, 1'b0);
         seed = lfsr(seed);
         bus(1, SFP_DATA_OFS, seed[7:0], r);
         prev = clock_idle_level;
         edges = 0;
         per = 0;
         n = 0;
         while (edges < 2 && n < 2000) begin
            @(negedge pclk);
            n++;
            if (edges == 1) per++;
            if (sck_out !== prev && sck_out === ~clock_idle_level) edges++;
            prev = sck_out;
         end
         check("clock period", per, div_tab[i]);
         n = 0;
         do begin
            bus(0, SFP_CSR_OFS, 8'h00, r);
            n++;
         end while (r[CS_DONE] !== 1'b1 && n < 1000);
         if (r[CS_DONE] !== 1'b1) begin
            mismatches++;
            summarize();
         end
         bus(0, SFP_DATA_OFS, 8'h00, r);
         check("idle after byte", sck_out, clock_idle_level);
      end
      summarize();
   end
endmodule // spi_fault_power_and_control_bench
